/* hw/kms_pkg.sv */
// Purpose: shared constants and types of the key matrix scan encoder
// Assumes: one 100 MHz clock, ref_clk
// Notes: timing figures are kept in ns and turned into cycle counts here
package kms_pkg;

    // ----------------------------------------------------------------
    // clock and timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    // least time a column is held before its rows are sampled
    localparam int SETTLE_NS = 1000;
    localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // successive complete scans with one pattern before a press counts
    localparam int MATCH_SCANS = 4;

    // ----------------------------------------------------------------
    // matrix size and field widths
    // ----------------------------------------------------------------
    localparam int NUM_COLS = 4;
    localparam int NUM_ROWS = 4;
    localparam int COL_IDX_W = 4;
    localparam int KEY_CODE_W = 4;
    localparam int PRECODE_W = 4;

    // ----------------------------------------------------------------
    // key position codes
    // ----------------------------------------------------------------
    localparam logic [KEY_CODE_W-1:0] CODE_NONE = 4'h0;
    localparam logic [KEY_CODE_W-1:0] CODE_MULTI = 4'hF;

    typedef logic [COL_IDX_W-1:0] kms_col_idx_t;
    typedef logic [KEY_CODE_W-1:0] kms_code_t;

    // probe -> scan -> judge -> report, one bit changes per step except judge -> probe, which changes both
    typedef enum logic [1:0] {
        KMS_PROBE = 2'h0,
        KMS_SCAN = 2'h1,
        KMS_JUDGE = 2'h3,
        KMS_REPORT = 2'h2
    } kms_state_t;

    // one accepted key report
    typedef struct packed {
        logic valid;
        kms_col_idx_t col;
        kms_code_t code;
    } kms_report_t;

endpackage

/* hw/kms_key_position_encode.sv */
// Purpose: turns one column reading into a key position code
// Assumes: CODE_W wide enough for W+1 plus an all-ones multi-press code
// Notes: purely combinational; the caller registers the result
`timescale 1ns/100ps
module kms_key_position_encode #(
    parameter int W = 4,
    parameter int CODE_W = $clog2(W + 1) + 1
) (
    input wire logic [W-1:0] workNibble,
    output logic [CODE_W-1:0] keyCode
);

    logic seen;
    logic multi;
    logic [CODE_W-1:0] pos;

    always_comb begin
        seen = 1'b0;
        multi = 1'b0;
        pos = '0;
        for (int i = 0; i < W; i++) begin
            if (workNibble[i]) begin
                multi = multi | seen;
                seen = 1'b1;
                pos = CODE_W'(i + 1);
            end
        end
        if (!seen) begin
            keyCode = '0;
        end else if (multi) begin
            keyCode = '1;
        end else begin
            keyCode = pos;
        end
    end

endmodule

/* hw/kms_scanner.sv */
// Purpose: scans a key switch matrix, debounces it and reports key codes
// Assumes: rows pulled high outside, a closed key pulls its row to the
//   driven column; columns are open-drain, so tied columns are zero dominant
// Notes: precoded keyboards are served when precodeMode is high
`timescale 1ns/100ps
module kms_scanner #(
    parameter int NUM_COLS = kms_pkg::NUM_COLS,
    parameter int NUM_ROWS = kms_pkg::NUM_ROWS,
    parameter int SETTLE_CYCLES = kms_pkg::SETTLE_CYCLES,
    parameter int MATCH_SCANS = kms_pkg::MATCH_SCANS
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [NUM_ROWS-1:0] rowSense_n,
    output logic [NUM_COLS-1:0] colOut,
    output logic [NUM_COLS-1:0] colOe,
    input wire logic precodeMode,
    input wire logic [kms_pkg::PRECODE_W-1:0] precodeData,
    input wire logic keyDownTest,
    output kms_pkg::kms_report_t keyReport
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    localparam int COLW = (NUM_COLS > 1) ? $clog2(NUM_COLS) : 1;
    localparam int MAPW = NUM_COLS * NUM_ROWS;
    localparam int SW = $clog2(SETTLE_CYCLES + 1);
    localparam int MW = $clog2(MATCH_SCANS + 1);
    localparam logic [SW-1:0] SETTLE_LAST = SW'(SETTLE_CYCLES - 1);
    localparam logic [COLW-1:0] COL_LAST = COLW'(NUM_COLS - 1);
    localparam logic [MW-1:0] MATCH_NEED = MW'(MATCH_SCANS);

    typedef struct packed {
        kms_pkg::kms_state_t fsm;
        logic [COLW-1:0] col;
        logic [SW-1:0] settle;
        logic [MAPW-1:0] scanMap;
        logic [MAPW-1:0] prevMap;
        logic [MW-1:0] matchCnt;
        logic accepted;
        logic [NUM_ROWS-1:0] rowMeta;
        logic [NUM_ROWS-1:0] rowSync;
        logic kdMeta;
        logic kdSync;
        logic kdPrev;
        logic [kms_pkg::PRECODE_W-1:0] pcMeta;
        logic [kms_pkg::PRECODE_W-1:0] pcSync;
        logic [NUM_COLS-1:0] colOe;
        kms_pkg::kms_report_t rep;
    } kms_state_reg_t;

    kms_state_reg_t s_r;
    kms_state_reg_t s_nxt;

    logic [NUM_ROWS-1:0] workNibble;
    logic [NUM_ROWS-1:0] encIn;
    kms_pkg::kms_code_t encOut;

    function automatic logic [NUM_ROWS-1:0] mapNib(input logic [MAPW-1:0] m,
                                                  input logic [COLW-1:0] c);
        return m[c * NUM_ROWS +: NUM_ROWS];
    endfunction

    // ----------------------------------------------------------------
    // encoder
    // ----------------------------------------------------------------
    // a closed key pulls its row low, so a pressed key reads as one
    assign workNibble = ~s_r.rowSync;
    assign encIn = (s_r.fsm == kms_pkg::KMS_REPORT) ? mapNib(s_r.prevMap, s_r.col)
                                                    : workNibble;

    kms_key_position_encode #(
        .W(NUM_ROWS),
        .CODE_W(kms_pkg::KEY_CODE_W)
    ) u_encode (
        .workNibble(encIn),
        .keyCode(encOut)
    );

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [MW-1:0] cntNew;
        cntNew = '0;
        s_nxt = s_r;
        s_nxt.rowMeta = rowSense_n;
        s_nxt.rowSync = s_r.rowMeta;
        s_nxt.kdMeta = keyDownTest;
        s_nxt.kdSync = s_r.kdMeta;
        s_nxt.kdPrev = s_r.kdSync;
        s_nxt.pcMeta = precodeData;
        s_nxt.pcSync = s_r.pcMeta;
        s_nxt.rep.valid = 1'b0;
        case (s_r.fsm)
            kms_pkg::KMS_PROBE: begin
                if (precodeMode) begin
                    s_nxt.settle = '0;
                    if (s_r.kdSync && !s_r.kdPrev) begin
                        s_nxt.rep.valid = 1'b1;
                        s_nxt.rep.col = '0;
                        s_nxt.rep.code = kms_pkg::kms_code_t'(s_r.pcSync);
                    end
                end else if (s_r.settle == SETTLE_LAST) begin
                    s_nxt.settle = '0;
                    // any row low while all columns are low: worth a scan
                    if (|workNibble) begin
                        s_nxt.fsm = kms_pkg::KMS_SCAN;
                        s_nxt.col = '0;
                    end else begin
                        s_nxt.matchCnt = '0;
                        s_nxt.prevMap = '0;
                        s_nxt.accepted = 1'b0;
                    end
                end else begin
                    s_nxt.settle = s_r.settle + SW'(1);
                end
            end
            kms_pkg::KMS_SCAN: begin
                if (s_r.settle == SETTLE_LAST) begin
                    s_nxt.settle = '0;
                    s_nxt.scanMap[s_r.col * NUM_ROWS +: NUM_ROWS] = workNibble;
                    if (s_r.col == COL_LAST) begin
                        s_nxt.fsm = kms_pkg::KMS_JUDGE;
                    end else begin
                        s_nxt.col = s_r.col + COLW'(1);
                    end
                end else begin
                    s_nxt.settle = s_r.settle + SW'(1);
                end
            end
            kms_pkg::KMS_JUDGE: begin
                s_nxt.col = '0;
                s_nxt.fsm = kms_pkg::KMS_PROBE;
                if (s_r.scanMap == '0) begin
                    s_nxt.matchCnt = '0;
                    s_nxt.prevMap = '0;
                    s_nxt.accepted = 1'b0;
                end else begin
                    // a differing pattern starts the count again
                    if (s_r.scanMap != s_r.prevMap) begin
                        cntNew = MW'(1);
                        s_nxt.accepted = 1'b0;
                    end else if (s_r.matchCnt < MATCH_NEED) begin
                        cntNew = s_r.matchCnt + MW'(1);
                    end else begin
                        cntNew = s_r.matchCnt;
                    end
                    s_nxt.prevMap = s_r.scanMap;
                    s_nxt.matchCnt = cntNew;
                    if (cntNew == MATCH_NEED && !s_nxt.accepted) begin
                        s_nxt.accepted = 1'b1;
                        s_nxt.fsm = kms_pkg::KMS_REPORT;
                    end
                end
            end
            kms_pkg::KMS_REPORT: begin
                if (|encIn) begin
                    s_nxt.rep.valid = 1'b1;
                    s_nxt.rep.col = kms_pkg::kms_col_idx_t'(s_r.col);
                    s_nxt.rep.code = encOut;
                end
                if (s_r.col == COL_LAST) begin
                    s_nxt.fsm = kms_pkg::KMS_PROBE;
                    s_nxt.col = '0;
                end else begin
                    s_nxt.col = s_r.col + COLW'(1);
                end
            end
            default: begin
                s_nxt.fsm = kms_pkg::KMS_PROBE;
                s_nxt.col = '0;
                s_nxt.settle = '0;
            end
        endcase
        // open-drain columns: enable means pulled low, released reads high
        if (s_nxt.fsm == kms_pkg::KMS_SCAN) begin
            s_nxt.colOe = NUM_COLS'(1) << s_nxt.col;
        end else if (s_nxt.fsm == kms_pkg::KMS_PROBE && !precodeMode) begin
            s_nxt.colOe = '1;
        end else begin
            s_nxt.colOe = '0;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
            s_r.colOe <= '1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // only ever drives low, so tied columns give a wired-AND
    assign colOut = '0;
    assign colOe = s_r.colOe;
    assign keyReport = s_r.rep;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    property p_enc_zero;
        encIn == '0 |-> encOut == kms_pkg::CODE_NONE;
    endproperty
    a_enc_zero: assert property (p_enc_zero) else $error("empty column not coded zero");

    property p_enc_multi;
        $countones(encIn) > 1 |-> encOut == kms_pkg::CODE_MULTI;
    endproperty
    a_enc_multi: assert property (p_enc_multi) else $error("multi press not all ones");

    property p_enc_one;
        $onehot(encIn) |-> (NUM_ROWS'(1) << (encOut - 4'h1)) == encIn;
    endproperty
    a_enc_one: assert property (p_enc_one) else $error("single press code wrong");

    property p_one_low;
        s_r.fsm == kms_pkg::KMS_SCAN |-> $onehot(colOe) && colOe[s_r.col];
    endproperty
    a_one_low: assert property (p_one_low) else $error("scan not one low column");

    property p_col_step;
        s_r.fsm == kms_pkg::KMS_SCAN && s_r.settle != SETTLE_LAST |=> $stable(s_r.col);
    endproperty
    a_col_step: assert property (p_col_step) else $error("column left before sampling");

    property p_probe_all;
        s_r.fsm == kms_pkg::KMS_PROBE && !precodeMode && !$past(precodeMode)
            |-> colOe == '1;
    endproperty
    a_probe_all: assert property (p_probe_all) else $error("probe not all columns low");

    property p_report_nonzero;
        keyReport.valid && !precodeMode |-> keyReport.code != kms_pkg::CODE_NONE
            && s_r.matchCnt == MATCH_NEED;
    endproperty
    a_report_nonzero: assert property (p_report_nonzero) else $error("bad matrix report");

    property p_report_col;
        s_r.fsm == kms_pkg::KMS_REPORT && |encIn
            |=> keyReport.valid && keyReport.col == kms_pkg::kms_col_idx_t'($past(s_r.col));
    endproperty
    a_report_col: assert property (p_report_col) else $error("press not under its column");

    property p_precode;
        s_r.fsm == kms_pkg::KMS_PROBE && precodeMode && s_r.kdSync && !s_r.kdPrev
            |=> keyReport.valid && keyReport.code == $past(s_r.pcSync);
    endproperty
    a_precode: assert property (p_precode) else $error("precoded key not reported");

    property p_raw_invert;
        // the encoder sees the row pins of two edges back, inverted
        s_r.fsm == kms_pkg::KMS_SCAN |-> encIn == ~$past(rowSense_n, 2);
    endproperty
    a_raw_invert: assert property (p_raw_invert) else $error("rows not inverted");

    c_scan: cover property (s_r.fsm == kms_pkg::KMS_PROBE ##1 s_r.fsm == kms_pkg::KMS_SCAN);
    c_accept: cover property (s_r.fsm == kms_pkg::KMS_REPORT && keyReport.valid);
    c_multi: cover property (keyReport.valid && keyReport.code == kms_pkg::CODE_MULTI);
    c_precode: cover property (keyReport.valid && precodeMode);

endmodule

/* testbench/kms_key_matrix.sv */
// Purpose: behavioural matrix of key switches on the scanner's row and column pins
// Assumes: rows pulled high outside; columns are open drain
// Notes: key bit index is col*NUM_ROWS+row; a closed key joins its row to its column
`timescale 1ns/100ps
module kms_key_matrix #(
    parameter int NUM_COLS = 4,
    parameter int NUM_ROWS = 4
) (
    input wire logic [NUM_COLS-1:0] colOut,
    input wire logic [NUM_COLS-1:0] colOe,
    input wire logic [NUM_COLS*NUM_ROWS-1:0] keys,
    output logic [NUM_ROWS-1:0] rowSense_n
);
    logic [NUM_COLS-1:0] colLevel;

    // a released column floats up through its pull-up
    assign colLevel = (colOe & colOut) | ~colOe;

    always_comb begin
        // row pull-ups hold every idle row high
        rowSense_n = '1;
        for (int r = 0; r < NUM_ROWS; r++) begin
            for (int c = 0; c < NUM_COLS; c++) begin
                if (keys[c*NUM_ROWS+r]) begin
                    // several closed keys on a row: any low column wins
                    rowSense_n[r] = rowSense_n[r] & colLevel[c];
                end
            end
        end
    end
endmodule

/* testbench/kms_scanner_tb.sv */
// Purpose: self-checking bench of the scanner and its key position encoder
// Assumes: short settle count of 3 cycles keeps each full scan near 16 cycles
// Notes: inputs change on the falling edge, outputs are read there too
`timescale 1ns/100ps
module kms_scanner_tb;
    localparam int S = 3;
    localparam int M = 4;
    localparam int NC = 4;
    localparam int NR = 4;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [NR-1:0] rowSense_n;
    logic [NC-1:0] colOut;
    logic [NC-1:0] colOe;
    logic precodeMode = 1'b0;
    logic [3:0] precodeData = 4'h0;
    logic keyDownTest = 1'b0;
    logic [NC*NR-1:0] keys = '0;
    kms_pkg::kms_report_t keyReport;
    int n_errors = 0;
    int num_checks = 0;
    int waited = 0;
    // closed keys in the high bits, the report they must give in the low nine bits;
    // a zero report means no report at all
    logic [24:0] cases [8] = '{
        {16'h0000, 9'h000},
        {16'h0001, 9'h101},
        {16'h0020, 9'h112},
        {16'h0200, 9'h122},
        {16'h0400, 9'h123},
        {16'h8000, 9'h134},
        {16'h0090, 9'h11F},
        {16'hF000, 9'h13F}
    };

    always #5 ref_clk = ~ref_clk;

    kms_scanner #(.NUM_COLS(NC), .NUM_ROWS(NR), .SETTLE_CYCLES(S), .MATCH_SCANS(M))
    i_kms_scanner (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .rowSense_n(rowSense_n),
        .colOut(colOut),
        .colOe(colOe),
        .precodeMode(precodeMode),
        .precodeData(precodeData),
        .keyDownTest(keyDownTest),
        .keyReport(keyReport)
    );

    kms_key_matrix #(.NUM_COLS(NC), .NUM_ROWS(NR)) i_kms_key_matrix (
        .colOut(colOut),
        .colOe(colOe),
        .keys(keys),
        .rowSense_n(rowSense_n)
    );

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic stop_test;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [8:0] got, input logic [8:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    // bounded wait for a report pulse; a hang ends the run
    task automatic wait_report(input int limit);
        waited = 0;
        while (keyReport.valid !== 1'b1) begin
            @(negedge ref_clk);
            waited++;
            if (waited > limit) begin
                n_errors++;
                $display("MISMATCH t=%0t no report seen", $time);
                stop_test();
            end
        end
    endtask

    task automatic quiet(input int n);
        num_checks++;
        repeat (n) begin
            @(negedge ref_clk);
            if (keyReport.valid !== 1'b0) begin
                n_errors++;
                $display("MISMATCH t=%0t unexpected report", $time);
            end
        end
    endtask

    // column enables are all, none or exactly one, and the drive value stays low
    always @(negedge ref_clk) begin
        if (rst_n === 1'b1 && precodeMode === 1'b0) begin
            if (colOut !== '0 || (colOe !== '1 && colOe !== '0 && !$onehot(colOe))) begin
                n_errors++;
                $display("MISMATCH t=%0t column drive %b", $time, colOe);
            end
        end
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        repeat (3) @(negedge ref_clk);
        check({5'h0, colOe}, 9'h00F, "reset columns");
        check(keyReport, 9'h000, "reset report");
        rst_n = 1'b1;
        // every pattern goes through the scanner and its encoder
        foreach (cases[i]) begin
            keys = cases[i][24:9];
            if (cases[i][8:0] == 9'h000) begin
                quiet(100);
            end else begin
                wait_report(400);
                check({8'h00, waited >= M * NC * S}, 9'h001, "debounce too short");
                check(keyReport, cases[i][8:0], "matrix key");
                quiet(100);
            end
            keys = '0;
            repeat (40) @(negedge ref_clk);
        end
        // a pattern that changes before acceptance starts the count again
        keys = 16'h0001;
        repeat (40) @(negedge ref_clk);
        keys = 16'h0010;
        wait_report(400);
        check({8'h00, waited >= M * NC * S}, 9'h001, "debounce not restarted");
        check(keyReport, 9'h111, "changed pattern");
        keys = '0;
        repeat (60) @(negedge ref_clk);
        // one row, two columns: both must be told apart
        keys = 16'h4004;
        wait_report(400);
        check(keyReport, 9'h103, "row first column");
        @(negedge ref_clk);
        wait_report(8);
        check(keyReport, 9'h133, "row last column");
        keys = '0;
        repeat (60) @(negedge ref_clk);
        // precoded keyboard
        precodeMode = 1'b1;
        precodeData = 4'hA;
        repeat (5) @(negedge ref_clk);
        check({5'h0, colOe}, 9'h000, "precode columns");
        keyDownTest = 1'b1;
        wait_report(10);
        check(keyReport, 9'h10A, "precode report");
        quiet(30);
        keyDownTest = 1'b0;
        precodeMode = 1'b0;
        // reset in mid-scan
        keys = 16'h0200;
        repeat (40) @(negedge ref_clk);
        rst_n = 1'b0;
        #1;
        check({5'h0, colOe}, 9'h00F, "second reset columns");
        check(keyReport, 9'h000, "second reset report");
        repeat (3) @(negedge ref_clk);
        rst_n = 1'b1;
        @(negedge ref_clk);
        check({5'h0, colOe}, 9'h00F, "columns after second release");
        // the held key must be debounced afresh after the reset
        wait_report(400);
        check({8'h00, waited >= M * NC * S}, 9'h001, "debounce after reset");
        check(keyReport, 9'h122, "key after reset");
        stop_test();
    end
endmodule
